// File: include/gpodac_pkg.sv
package gpodac_pkg;

    localparam int GPODAC_WIDTH = 16;

    // register byte addresses on the apb bus
    localparam logic [7:0] GPODAC_ADDR_PORT = 8'h00;
    localparam logic [7:0] GPODAC_ADDR_LATCH = 8'h04;
    localparam logic [7:0] GPODAC_ADDR_DIR = 8'h08;
    localparam logic [7:0] GPODAC_ADDR_ODSEL = 8'h0C;
    localparam logic [7:0] GPODAC_ADDR_ANCFG = 8'h10;

    // values after reset: all pins inputs, push-pull, digital
    localparam logic [15:0] GPODAC_RST_LATCH = 16'h0000;
    localparam logic [15:0] GPODAC_RST_DIR = 16'hFFFF;
    localparam logic [15:0] GPODAC_RST_ODSEL = 16'h0000;
    localparam logic [15:0] GPODAC_RST_ANCFG = 16'h0000;

    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
    } gpodac_pad_drive_type;

endpackage

// File: core/gpodac_pin_cell.sv
`timescale 1ns/10ps
module gpodac_pin_cell
    import gpodac_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // per-pin configuration
    input wire logic latch_i,
    input wire logic dir_in_i,
    input wire logic od_sel_i,
    input wire logic analog_i,
    // pad side
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe_o,
    // core side
    output logic port_rd_o,
    output logic adc_o,
    output logic adc_valid_o
);
    logic sync1_q;
    logic sync2_q;
    logic drive_en;

    // direction bit one is input, zero is output
    assign drive_en = ~dir_in_i;
    // open drain drives low only, push-pull drives both levels
    assign pad_o = od_sel_i ? 1'b0 : latch_i;
    assign pad_oe_o = drive_en & (od_sel_i ? ~latch_i : 1'b1);
    // analog pin left as output keeps driving; converter sees the driven level
    assign adc_o = drive_en ? latch_i : pad_i;
    // digital pins are never flagged valid; their level still drives adc_o
    assign adc_valid_o = analog_i;
    // analog pins read as zero through the port path
    assign port_rd_o = sync2_q & ~analog_i;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= drive_en ? latch_i : pad_i;
            sync2_q <= sync1_q;
        end
    end
endmodule // gpodac_pin_cell

// File: core/gpodac_port.sv
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/10ps
// Contract
// - set open-drain select bit makes that pin's output open-drain
// - open-drain select is per pin, one select register per port
// - analog pin with direction output keeps driving; converter samples that level
// - port data read returns zero for analog-configured pins
// - digital-input pins pass their pad level to the converter, never with valid set
// - direction one is input, zero is output
module gpodac_port
    import gpodac_pkg::*;
#(
    parameter int WIDTH = GPODAC_WIDTH
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // pads
    input wire logic [WIDTH-1:0] pad_i,
    output logic [WIDTH-1:0] pad_o,
    output logic [WIDTH-1:0] pad_oe_o,
    // converter side
    output logic [WIDTH-1:0] adc_level_o,
    output logic [WIDTH-1:0] adc_valid_o
);
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] odsel_q;
    logic [WIDTH-1:0] ancfg_q;
    logic [WIDTH-1:0] port_rd;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic access;
    logic wr_en;
    logic sel_port;
    logic sel_latch;
    logic sel_dir;
    logic sel_od;
    logic sel_an;
    logic mapped;

    assign access = psel_i & penable_i;
    assign sel_port = paddr_i == GPODAC_ADDR_PORT;
    assign sel_latch = paddr_i == GPODAC_ADDR_LATCH;
    assign sel_dir = paddr_i == GPODAC_ADDR_DIR;
    assign sel_od = paddr_i == GPODAC_ADDR_ODSEL;
    assign sel_an = paddr_i == GPODAC_ADDR_ANCFG;
    assign mapped = sel_port | sel_latch | sel_dir | sel_od | sel_an;
    assign wr_en = access & pwrite_i & mapped;
    // zero-wait slave; unmapped addresses answer with an error
    assign pready_o = 1'b1;
    assign pslverr_o = access & ~mapped;
    assign prdata_o = rdata_q;

    // port read shows pins one pipeline behind; the required gap covers it
    assign rdata_d = sel_port ? {{(32-WIDTH){1'b0}}, port_rd} :
                     sel_latch ? {{(32-WIDTH){1'b0}}, latch_q} :
                     sel_dir ? {{(32-WIDTH){1'b0}}, dir_q} :
                     sel_od ? {{(32-WIDTH){1'b0}}, odsel_q} :
                     sel_an ? {{(32-WIDTH){1'b0}}, ancfg_q} : 32'h0000_0000;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            latch_q <= GPODAC_RST_LATCH[WIDTH-1:0];
            dir_q <= GPODAC_RST_DIR[WIDTH-1:0];
            odsel_q <= GPODAC_RST_ODSEL[WIDTH-1:0];
            ancfg_q <= GPODAC_RST_ANCFG[WIDTH-1:0];
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            if (wr_en & (sel_port | sel_latch))
                latch_q <= pwdata_i[WIDTH-1:0];
            if (wr_en & sel_dir)
                dir_q <= pwdata_i[WIDTH-1:0];
            if (wr_en & sel_od)
                odsel_q <= pwdata_i[WIDTH-1:0];
            // analog setting is not forced onto direction; software owns that
            if (wr_en & sel_an)
                ancfg_q <= pwdata_i[WIDTH-1:0];
            if (psel_i & ~penable_i & ~pwrite_i)
                rdata_q <= rdata_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_pin
            gpodac_pin_cell u_cell (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .latch_i(latch_q[g]),
                .dir_in_i(dir_q[g]),
                .od_sel_i(odsel_q[g]),
                .analog_i(ancfg_q[g]),
                .pad_i(pad_i[g]),
                .pad_o(pad_o[g]),
                .pad_oe_o(pad_oe_o[g]),
                .port_rd_o(port_rd[g]),
                .adc_o(adc_level_o[g]),
                .adc_valid_o(adc_valid_o[g])
            );
        end
    endgenerate
endmodule // gpodac_port

// File: verification/gpodac_pads.sv
`timescale 1ns/10ps
module gpodac_pads (input wire logic [15:0] d_i, oe_i, x_i, output logic [15:0] p_o);
    assign p_o = oe_i & d_i | ~oe_i & x_i; // released pins read the board
endmodule // gpodac_pads

// File: verification/gpodac_port_monitor.sv
`timescale 1ns/10ps
module gpodac_port_monitor
(
    input wire logic clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i, prdata_o,
    input wire logic [15:0] pad_o, pad_oe_o, adc_level_o, adc_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire acc = psel_i & penable_i;
    wire wr = acc & pwrite_i;
    wire [15:0] wd = pwdata_i[15:0];
    a_zero_wait: assert property (acc |-> pready_o) else $error("ready");
    a_bad_addr: assert property (acc && paddr_i > 8'h10 |-> pslverr_o) else $error("err");
    a_od_low: assert property (wr && paddr_i == 8'h0C |=> !(pad_o & $past(wd)))
        else $error("od");
    a_dir_out: assert property (wr && paddr_i == 8'h08 |=> !(pad_oe_o & $past(wd)))
        else $error("dir");
    a_adc_out: assert property (!((adc_level_o ^ pad_o) & pad_oe_o))
        else $error("adc");
    a_an_valid: assert property (wr && paddr_i == 8'h10 |=> adc_valid_o == $past(wd))
        else $error("valid");
    a_an_read0: assert property (psel_i && !penable_i && !pwrite_i && !paddr_i
        |=> !(prdata_o[15:0] & adc_valid_o)) else $error("an");
    cover property (wr);
    cover property (pslverr_o);
    cover property (acc && !paddr_i);
endmodule // gpodac_port_monitor
bind gpodac_port gpodac_port_monitor i_mon (.*);

// File: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
    logic [7:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o;
    logic [15:0] pad_i, pad_o, pad_oe_o, adc_level_o, adc_valid_o, ext_i = 16'h3CFF;
    int bad_count = 0, total_checks = 0, cyc = 0;
    initial forever #20 clk_i = ~clk_i;
    gpodac_port i_dut (.*);
    gpodac_pads i_pads (.d_i(pad_o), .oe_i(pad_oe_o), .x_i(ext_i), .p_o(pad_i));
    task automatic chk(input logic [31:0] g, e);
        total_checks++;
        if (g !== e)
            $display("ERROR %0t %h %h", $time, g, e);
        bad_count += int'(g !== e);
    endtask
    task automatic apb(input logic [31:0] w, a, d, e);
        psel_i <= 1;
        pwrite_i <= w[0];
        paddr_i <= a[7:0];
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        if (!w)
            chk(prdata_o, e);
        psel_i <= 0;
        penable_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic tally_and_finish;
        $display("%0d %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog: a hung wait counts as a mismatch and still reaches the verdict
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            $display("ERROR %0t %h %h", $time, cyc, 2000);
            bad_count++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 0;
        apb(0, 'h8, 0, 'hFFFF);
        apb(1, 'h8, 'hFF00, 0);
        apb(1, 0, 'hA5, 0);
        apb(0, 'h4, 0, 'hA5);
        chk(pad_oe_o, 'hFF);
        apb(0, 0, 0, 'h3CA5);
        apb(1, 'hC, 'hF, 0);
        chk(pad_oe_o, 'hFA);
        chk(pad_o, 'hA0);
        chk(adc_level_o, 'h3CA5);
        apb(1, 'h10, 'hF0F, 0);
        chk(adc_valid_o, 'hF0F);
        apb(0, 0, 0, 'h30A0);
        apb(0, 'h20, 0, 0);
        tally_and_finish;
    end
endmodule // tb_top
